//--- src/plcr_pkg.sv
/*
 plcr_pkg: shared constants, state codes and coding functions for the
 line coding and recovery block.
 Assumes one core clock at 10 MHz; one line bit (100 Mbps) or one
 Manchester half cell (10 Mbps) moves per core clock.
*/
`default_nettype none
package plcr_pkg;
	// clock and time figures
	localparam int CLK_NS        = 100;
	localparam int WDOG_WIN_NS   = 8000;
	localparam int WDOG_WIN_CYC  = WDOG_WIN_NS / CLK_NS;
	localparam int RETRAIN_NS    = 200000;
	localparam int RETRAIN_CYC   = (RETRAIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_WIN_US   = 1000;
	localparam int SYNC_WIN_CYC  = (SYNC_WIN_US * 1000) / CLK_NS;
	localparam int DEV_PCT       = 3;
	localparam int PCT_FULL      = 100;
	localparam int REF_TICKS     = 20;
	// widths and counts
	localparam int NIB_W         = 4;
	localparam int SYM_W         = 5;
	localparam int FIFO_W        = 5;
	localparam int FIFO_D        = 8;
	localparam int SCR_W         = 11;
	localparam int SCR_TAP_HI    = 10;
	localparam int SCR_TAP_LO    = 8;
	localparam logic [10:0] SCR_SEED = 11'h7ff;
	localparam logic [4:0] IDLE_ONES_MIN = 5'h19;
	localparam logic [4:0] LOCK_HALVES   = 5'h18;
	localparam logic [2:0] LAST_BIT_100  = 3'h4;
	localparam logic [2:0] LAST_HALF_10  = 3'h7;
	localparam logic [2:0] TXC_HI_100    = 3'h2;
	localparam logic [2:0] TXC_HI_10     = 3'h4;
	localparam logic [2:0] RXC_HI_100    = 3'h3;
	// code groups and nibbles
	localparam logic [4:0] CG_IDLE = 5'h1f;
	localparam logic [4:0] CG_J    = 5'h18;
	localparam logic [4:0] CG_K    = 5'h11;
	localparam logic [4:0] CG_T    = 5'h0d;
	localparam logic [4:0] CG_R    = 5'h07;
	localparam logic [4:0] CG_H    = 5'h04;
	localparam logic [3:0] NIB_SSD  = 4'h5;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [7:0] SOI_CELLS = 8'hff;
	localparam logic [7:0] OFF_CELLS = 8'h00;

	typedef enum logic [5:0] {
		TX_IDLE = 6'b000001,
		TX_K    = 6'b000010,
		TX_DATA = 6'b000100,
		TX_R    = 6'b001000,
		TX_MAN  = 6'b010000,
		TX_SOI  = 6'b100000
	} plcr_tx_st_t;

	typedef enum logic [4:0] {
		RX_HUNT = 5'b00001,
		RX_SSD  = 5'b00010,
		RX_PKT  = 5'b00100,
		RX_END  = 5'b01000,
		RX_MAN  = 5'b10000
	} plcr_rx_st_t;

	// nibble to data code group
	function automatic logic [4:0] plcr_enc(input logic [3:0] nib);
		logic [4:0] cg;
		cg = 5'h1e;
		unique case (nib)
			4'h0: cg = 5'h1e;
			4'h1: cg = 5'h09;
			4'h2: cg = 5'h14;
			4'h3: cg = 5'h15;
			4'h4: cg = 5'h0a;
			4'h5: cg = 5'h0b;
			4'h6: cg = 5'h0e;
			4'h7: cg = 5'h0f;
			4'h8: cg = 5'h12;
			4'h9: cg = 5'h13;
			4'ha: cg = 5'h16;
			4'hb: cg = 5'h17;
			4'hc: cg = 5'h1a;
			4'hd: cg = 5'h1b;
			4'he: cg = 5'h1c;
			4'hf: cg = 5'h1d;
		endcase
		return cg;
	endfunction

	// code group to {data_ok, nibble}; anything else is zero
	function automatic logic [4:0] plcr_dec(input logic [4:0] cg);
		logic [4:0] r;
		r = {1'b0, NIB_ZERO};
		for (int i = 0; i < 16; i++) begin
			if (plcr_enc(4'(i)) == cg) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	// first half complement, second half true, lsb first
	function automatic logic [7:0] plcr_man(input logic [3:0] n);
		return {~n[0], n[0], ~n[1], n[1], ~n[2], n[2], ~n[3], n[3]};
	endfunction

	// watchdog deviation test in percent
	function automatic logic plcr_dev(input logic [7:0] cnt, input logic [7:0] ref_cnt);
		int diff;
		diff = (cnt > ref_cnt) ? int'(cnt) - int'(ref_cnt) : int'(ref_cnt) - int'(cnt);
		return (diff * PCT_FULL) > (int'(ref_cnt) * DEV_PCT);
	endfunction
endpackage
`default_nettype wire

//--- src/plcr_strm_if.sv
/*
 plcr_strm_if: valid/ready word stream between the block's own modules.
 Assumes both ends share one clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface plcr_strm_if #(parameter int W = 5);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

//--- src/plcr_fifo.sv
/*
 plcr_fifo: first-word-fall-through FIFO, width and depth as parameters.
 Assumes depth is a power of two and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module plcr_fifo #(
	parameter int W = 5,
	parameter int D = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	plcr_strm_if.snk wr_if,
	plcr_strm_if.src rd_if
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem_ff [D];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;

	// honest full and empty from the fill count
	assign wr_if.ready = cnt_ff != (AW + 1)'(D);
	assign rd_if.valid = cnt_ff != '0;
	assign rd_if.data  = mem_ff[rp_ff];
	assign push        = wr_if.valid & wr_if.ready;
	assign pop         = rd_if.valid & rd_if.ready;

	// storage needs no reset, the count guards reads
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_ff[wp_ff] <= wr_if.data;
		end
	end

	// pointers and fill count
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wp_ff  <= push ? wp_ff + 1'b1 : wp_ff;
			rp_ff  <= pop ? rp_ff + 1'b1 : rp_ff;
			cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule
`default_nettype wire

//--- src/plcr_top.sv
/*
 plcr_top: 4B5B/scrambler and Manchester coding paths, descrambler sync,
 code-group alignment, receive clock selection and PLL watchdog.
 Assumes line bits and analog status arrive asynchronously, MAC nibbles
 arrive on the core clock, and the MAC honours tx_ready_o.
*/
`timescale 1ns/100ps
`default_nettype none
module plcr_top #(
	parameter int SYNC_WIN = plcr_pkg::SYNC_WIN_CYC
) (
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       speed_100_i,
	input  wire logic                       status_clr_i,
	input  wire logic [plcr_pkg::NIB_W-1:0] txd_i,
	input  wire logic                       tx_en_i,
	output logic                            tx_ready_o,
	output logic                            tx_clk_o,
	output logic                            tx_line_o,
	output logic                            tx_line_oe_o,
	input  wire logic                       rx_line_i,
	input  wire logic                       squelch_ok_i,
	input  wire logic                       eq_settled_i,
	input  wire logic                       pll_tick_i,
	output logic                            pll_src_line_o,
	output logic                            rx_clk_o,
	output logic [plcr_pkg::NIB_W-1:0]      rxd_o,
	output logic                            rx_dv_o,
	output logic                            rx_er_o,
	output logic                            ssd_err_o,
	output logic                            esd_err_o,
	output logic                            code_err_o,
	output logic                            loss_sync_o,
	output logic                            retrain_o
);
	import plcr_pkg::*;

	localparam int TW = $clog2(SYNC_WIN + 1);

	plcr_strm_if #(.W(FIFO_W)) txw_if ();
	plcr_strm_if #(.W(FIFO_W)) txr_if ();

	plcr_fifo #(.W(FIFO_W), .D(FIFO_D)) u_tx_fifo (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.wr_if      (txw_if),
		.rd_if      (txr_if)
	);

	logic              mode_ff;
	logic              mode_chg;
	logic              tx_en_d_ff;
	plcr_tx_st_t       tx_st_ff;
	plcr_tx_st_t       nxt_tx_st;
	logic [7:0]        sh_ff;
	logic [7:0]        nxt_sh;
	logic [2:0]        tcnt_ff;
	logic              nxt_drive;
	logic              drive_ff;
	logic              load;
	logic [SCR_W-1:0]  scr_ff;
	logic              scr_key;
	logic              line_ff;
	logic              oe_ff;
	logic              txc_ff;
	logic [3:0]        s1_ff;
	logic [3:0]        s2_ff;
	logic              tick_d_ff;
	logic              tick_rise;
	logic              line_ok;
	logic              rx_bit;
	logic [SCR_W-1:0]  dsc_ff;
	logic              dkey;
	logic              descr;
	logic [4:0]        ones_ff;
	logic              ones_full;
	logic              synced_ff;
	logic [TW-1:0]     stmr_ff;
	logic [9:0]        win_ff;
	logic [9:0]        w;
	logic [4:0]        dec;
	logic              bound;
	plcr_rx_st_t       rx_st_ff;
	logic [2:0]        bcnt_ff;
	logic [4:0]        hcnt_ff;
	logic              prev_ff;
	logic [3:0]        nib_ff;
	logic [3:0]        rxd_ff;
	logic              dv_ff;
	logic              er_ff;
	logic              rxc_ff;
	logic              ssd_hit_ff;
	logic              esd_hit_ff;
	logic              code_hit_ff;
	logic              ssd_ff;
	logic              esd_ff;
	logic              code_ff;
	logic [6:0]        wcnt_ff;
	logic [7:0]        tick_cnt_ff;
	logic [10:0]       rtr_ff;

	// one speed latch steers both paths
	assign mode_chg = mode_ff != speed_100_i;
	always_ff @(posedge core_clk_i) begin
		mode_ff <= rst_i ? 1'b0 : speed_100_i;
	end

	// nibbles enter only under transmit enable; rising enable tags start
	assign txw_if.data  = {tx_en_i & ~tx_en_d_ff, txd_i};
	assign txw_if.valid = tx_en_i;
	assign tx_ready_o   = txw_if.ready;
	always_ff @(posedge core_clk_i) begin
		tx_en_d_ff <= rst_i ? 1'b0 : tx_en_i;
	end

	// next symbol chosen at each symbol boundary
	assign load = tcnt_ff == 3'h0;
	always_comb begin
		nxt_tx_st    = tx_st_ff;
		nxt_sh       = {CG_IDLE, 3'h0};
		nxt_drive    = mode_ff;
		txr_if.ready = 1'b0;
		unique case (tx_st_ff)
			TX_IDLE: begin
				if (mode_ff) begin
					// idle fill, J replaces first preamble nibble
					if (txr_if.valid && txr_if.data[NIB_W]) begin
						txr_if.ready = load;
						nxt_sh       = {CG_J, 3'h0};
						nxt_tx_st    = TX_K;
					end
				end else begin
					nxt_sh = OFF_CELLS;
					if (txr_if.valid && txr_if.data[NIB_W]) begin
						txr_if.ready = load;
						nxt_sh       = plcr_man(txr_if.data[NIB_W-1:0]);
						nxt_drive    = 1'b1;
						nxt_tx_st    = TX_MAN;
					end
				end
			end
			TX_K: begin
				txr_if.ready = load;
				nxt_sh       = {CG_K, 3'h0};
				nxt_tx_st    = TX_DATA;
			end
			TX_DATA: begin
				if (txr_if.valid && !txr_if.data[NIB_W]) begin
					txr_if.ready = load;
					nxt_sh       = {plcr_enc(txr_if.data[NIB_W-1:0]), 3'h0};
				end else if (txr_if.valid || !tx_en_i) begin
					// T then R closes the packet
					nxt_sh    = {CG_T, 3'h0};
					nxt_tx_st = TX_R;
				end else begin
					nxt_sh = {CG_H, 3'h0}; // underrun marker
				end
			end
			TX_R: begin
				nxt_sh    = {CG_R, 3'h0};
				nxt_tx_st = TX_IDLE;
			end
			TX_MAN: begin
				nxt_drive = 1'b1;
				if (txr_if.valid && !txr_if.data[NIB_W]) begin
					txr_if.ready = load;
					nxt_sh       = plcr_man(txr_if.data[NIB_W-1:0]);
				end else begin
					nxt_sh    = SOI_CELLS;
					nxt_tx_st = TX_SOI;
				end
			end
			TX_SOI: begin
				nxt_sh    = OFF_CELLS;
				nxt_drive = 1'b0;
				nxt_tx_st = TX_IDLE;
			end
		endcase
	end

	// symbol shifter: 5 bits at 100 Mbps, 8 half cells at 10 Mbps
	always_ff @(posedge core_clk_i) begin
		if (rst_i || mode_chg) begin
			tx_st_ff <= TX_IDLE;
			sh_ff    <= OFF_CELLS;
			tcnt_ff  <= 3'h0;
			drive_ff <= 1'b0;
		end else if (load) begin
			tx_st_ff <= nxt_tx_st;
			sh_ff    <= nxt_sh;
			tcnt_ff  <= mode_ff ? LAST_BIT_100 : LAST_HALF_10;
			drive_ff <= nxt_drive;
		end else begin
			sh_ff   <= {sh_ff[6:0], 1'b0};
			tcnt_ff <= tcnt_ff - 3'h1;
		end
	end

	// 11-bit key stream, x^11 + x^9 + 1
	assign scr_key = scr_ff[SCR_TAP_HI] ^ scr_ff[SCR_TAP_LO];
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			scr_ff <= SCR_SEED;
		end else if (mode_ff) begin
			scr_ff <= {scr_ff[SCR_W-2:0], scr_key};
		end
	end

	// scrambled only at 100 Mbps; clock output from the symbol count
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			line_ff <= 1'b0;
			oe_ff   <= 1'b0;
			txc_ff  <= 1'b0;
		end else begin
			line_ff <= mode_ff ? sh_ff[7] ^ scr_key : sh_ff[7];
			oe_ff   <= drive_ff;
			txc_ff  <= tcnt_ff >= (mode_ff ? TXC_HI_100 : TXC_HI_10);
		end
	end
	assign tx_line_o    = line_ff;
	assign tx_line_oe_o = oe_ff;
	assign tx_clk_o     = txc_ff;

	// two-stage sync: line, squelch, equalizer, pll tick
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s1_ff     <= 4'h0;
			s2_ff     <= 4'h0;
			tick_d_ff <= 1'b0;
		end else begin
			s1_ff     <= {pll_tick_i, eq_settled_i, squelch_ok_i, rx_line_i};
			s2_ff     <= s1_ff;
			tick_d_ff <= s2_ff[3];
		end
	end

	// line feeds the PLL only when squelch agrees, the equalizer too at 100 Mbps, and no retrain runs
	assign line_ok        = s2_ff[1] & (s2_ff[2] | ~mode_ff) & (rtr_ff == 11'h0);
	assign pll_src_line_o = line_ok;
	assign retrain_o      = rtr_ff != 11'h0;
	assign rx_bit = line_ok & s2_ff[0];

	// recovered ticks against the reference over each window
	assign tick_rise = s2_ff[3] & ~tick_d_ff;
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !line_ok) begin
			wcnt_ff     <= 7'h0;
			tick_cnt_ff <= 8'h0;
		end else if (wcnt_ff == 7'(WDOG_WIN_CYC - 1)) begin
			wcnt_ff     <= 7'h0;
			tick_cnt_ff <= 8'h0;
		end else begin
			wcnt_ff     <= wcnt_ff + 7'h1;
			tick_cnt_ff <= tick_cnt_ff + 8'(tick_rise);
		end
	end

	// retrain hold counted on the core clock
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rtr_ff <= 11'h0;
		// last cycle's edge counts too, else a clean clock reads one tick short
		end else if (line_ok && wcnt_ff == 7'(WDOG_WIN_CYC - 1)
				&& plcr_dev(tick_cnt_ff + 8'(tick_rise), 8'(REF_TICKS))) begin
			rtr_ff <= 11'(RETRAIN_CYC);
		end else if (rtr_ff != 11'h0) begin
			rtr_ff <= rtr_ff - 11'h1;
		end
	end

	// descrambler trains on idle, then free-runs
	assign dkey      = dsc_ff[SCR_TAP_HI] ^ dsc_ff[SCR_TAP_LO];
	assign descr     = rx_bit ^ dkey;
	assign ones_full = descr && ones_ff == IDLE_ONES_MIN - 5'h1;
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !mode_ff) begin
			dsc_ff    <= SCR_SEED;
			ones_ff   <= 5'h0;
			synced_ff <= 1'b0;
			stmr_ff   <= '0;
		end else begin
			dsc_ff  <= {dsc_ff[SCR_W-2:0], synced_ff ? dkey : ~rx_bit};
			ones_ff <= !descr ? 5'h0 : (ones_full ? ones_ff : ones_ff + 5'h1);
			// 25 idle ones restart the 1 ms window, expiry drops sync
			if (ones_full) begin
				synced_ff <= 1'b1;
				stmr_ff   <= '0;
			end else if (synced_ff && stmr_ff == TW'(SYNC_WIN - 1)) begin
				synced_ff <= 1'b0;
				stmr_ff   <= '0;
			end else begin
				stmr_ff <= synced_ff ? stmr_ff + 1'b1 : '0;
			end
		end
	end

	// group window and decode
	assign w     = {win_ff[8:0], descr};
	assign dec   = plcr_dec(w[4:0]);
	assign bound = bcnt_ff == LAST_BIT_100;
	always_ff @(posedge core_clk_i) begin
		win_ff  <= rst_i ? 10'h0 : w;
		prev_ff <= rst_i ? 1'b0 : rx_bit;
	end

	// receive framing and nibble output for both speeds
	always_ff @(posedge core_clk_i) begin
		ssd_hit_ff  <= 1'b0;
		esd_hit_ff  <= 1'b0;
		code_hit_ff <= 1'b0;
		if (rst_i || mode_chg) begin
			rx_st_ff <= RX_HUNT;
			bcnt_ff  <= 3'h0;
			hcnt_ff  <= 5'h0;
			nib_ff   <= NIB_ZERO;
			rxd_ff   <= NIB_ZERO;
			dv_ff    <= 1'b0;
			er_ff    <= 1'b0;
		end else if (mode_ff) begin
			bcnt_ff <= bound ? 3'h0 : bcnt_ff + 3'h1;
			unique case (rx_st_ff)
				RX_HUNT: begin
					// framing restarts on J after idle
					if (synced_ff && w[4:0] == CG_J && w[9:5] == CG_IDLE) begin
						bcnt_ff  <= 3'h0;
						rx_st_ff <= RX_SSD;
						rxd_ff   <= NIB_SSD;
						dv_ff    <= 1'b1;
						er_ff    <= 1'b0;
					end else if (bound) begin
						rxd_ff <= NIB_ZERO;
						dv_ff  <= 1'b0;
						er_ff  <= 1'b0;
					end
				end
				RX_SSD: if (bound) begin
					// second data-5 in place of K
					rxd_ff   <= w[4:0] == CG_K ? NIB_SSD : NIB_ZERO;
					// broken delimiter flagged on its nibble
					er_ff    <= w[4:0] != CG_K;
					ssd_hit_ff <= w[4:0] != CG_K;
					rx_st_ff <= w[4:0] == CG_K ? RX_PKT : RX_HUNT;
				end
				RX_PKT: if (bound) begin
					if (w[4:0] == CG_T) begin
						// zero nibble in place of T
						rxd_ff   <= NIB_ZERO;
						er_ff    <= 1'b0;
						rx_st_ff <= RX_END;
					end else if (w[4:0] == CG_IDLE) begin
						rxd_ff     <= NIB_ZERO;
						er_ff      <= 1'b1;
						esd_hit_ff <= 1'b1;
						rx_st_ff   <= RX_HUNT;
					end else begin
						rxd_ff      <= dec[3:0];
						er_ff       <= ~dec[4];
						code_hit_ff <= ~dec[4];
					end
				end
				RX_END: if (bound) begin
					// zero nibble in place of R
					rxd_ff     <= NIB_ZERO;
					er_ff      <= w[4:0] != CG_R;
					esd_hit_ff <= w[4:0] != CG_R;
					rx_st_ff   <= RX_HUNT;
				end
				RX_MAN: rx_st_ff <= RX_HUNT;
			endcase
			if (!synced_ff && rx_st_ff != RX_HUNT) begin
				rx_st_ff <= RX_HUNT;
			end
		end else begin
			er_ff   <= 1'b0;
			bcnt_ff <= bcnt_ff + 3'h1;
			unique case (rx_st_ff)
				RX_MAN: begin
					if (!line_ok) begin
						rx_st_ff <= RX_HUNT;
						rxd_ff   <= NIB_ZERO;
						dv_ff    <= 1'b0;
					end else if (bcnt_ff[0]) begin
						// no mid-cell transition means start of idle, dropped
						if (rx_bit == prev_ff) begin
							rx_st_ff <= RX_HUNT;
							rxd_ff   <= NIB_ZERO;
							dv_ff    <= 1'b0;
						end else begin
							nib_ff <= {rx_bit, nib_ff[3:1]};
							if (bcnt_ff == LAST_HALF_10) begin
								rxd_ff <= {rx_bit, nib_ff[3:1]};
								dv_ff  <= 1'b1;
							end
						end
					end
				end
				default: begin
					rx_st_ff <= RX_HUNT;
					rxd_ff   <= NIB_ZERO;
					dv_ff    <= 1'b0;
					// lock within 12 bit times, then frame on a mid-cell edge
					if (!line_ok) begin
						hcnt_ff <= 5'h0;
					end else if (hcnt_ff != LOCK_HALVES) begin
						hcnt_ff <= hcnt_ff + 5'h1;
					end else if (rx_bit != prev_ff) begin
						nib_ff   <= {rx_bit, 3'h0};
						bcnt_ff  <= 3'h2;
						hcnt_ff  <= 5'h0;
						rx_st_ff <= RX_MAN;
					end
				end
			endcase
		end
	end

	// nibble clock from the group count; transmit clock until framed
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rxc_ff <= 1'b0;
		end else if (rx_st_ff == RX_HUNT) begin
			rxc_ff <= txc_ff;
		end else begin
			rxc_ff <= bcnt_ff < (mode_ff ? RXC_HI_100 : TXC_HI_10);
		end
	end

	// sticky error bits, a new hit beats the clear
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ssd_ff  <= 1'b0;
			esd_ff  <= 1'b0;
			code_ff <= 1'b0;
		end else begin
			ssd_ff  <= ssd_hit_ff | (ssd_ff & ~status_clr_i);
			esd_ff  <= esd_hit_ff | (esd_ff & ~status_clr_i);
			code_ff <= code_hit_ff | (code_ff & ~status_clr_i);
		end
	end

	assign rxd_o      = rxd_ff;
	assign rx_dv_o    = dv_ff;
	// no receive error at 10 Mbps
	assign rx_er_o    = er_ff & mode_ff;
	assign rx_clk_o   = rxc_ff;
	assign ssd_err_o  = ssd_ff;
	assign esd_err_o  = esd_ff;
	assign code_err_o = code_ff;
	// loss of sync held while unsynchronized
	assign loss_sync_o = ~synced_ff;
endmodule
`default_nettype wire

//--- test/plcr_top_chk.sv
/*
 plcr_top_chk: port assertions for plcr_top.
 Assumes a bind onto plcr_top and one core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module plcr_top_chk (
	input wire logic	core_clk_i,
	input wire logic	rst_i,
	input wire logic	speed_100_i,
	input wire logic	squelch_ok_i,
	input wire logic	eq_settled_i,
	input wire logic	tx_clk_o,
	input wire logic	tx_line_oe_o,
	input wire logic	pll_src_line_o,
	input wire logic	rx_clk_o,
	input wire logic [plcr_pkg::NIB_W-1:0]	rxd_o,
	input wire logic	rx_dv_o,
	input wire logic	rx_er_o,
	input wire logic	loss_sync_o,
	input wire logic	retrain_o
);
	import plcr_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// repeats give the speed register and sync chains time to settle
	a_slow_no_er: assert property ((!speed_100_i)[*3] |-> !rx_er_o) else $error("rx error at 10");
	a_slow_sync_flag: assert property ((!speed_100_i)[*3] |-> loss_sync_o) else $error("sync at 10");
	// speed change resets the shifter, so the enable needs one more cycle
	a_fast_line_oe: assert property (speed_100_i[*4] |-> tx_line_oe_o) else $error("line idle at 100");
	// while hunting the receive clock is the transmit clock one cycle later
	a_rx_clk_hunt: assert property (speed_100_i[*3] ##0 !rx_dv_o |=> rx_clk_o == $past(tx_clk_o))
		else $error("rx clock not following tx clock");
	a_squelch_src_gate: assert property ((!squelch_ok_i)[*4] |-> !pll_src_line_o) else $error("pll on line");
	a_eq_src_gate: assert property ((speed_100_i && !eq_settled_i)[*5] |-> !pll_src_line_o)
		else $error("pll on line before eq");
	a_retrain_src: assert property (retrain_o |-> !pll_src_line_o) else $error("pll on line in retrain");
	a_idle_rxd_low: assert property (!rx_dv_o |-> rxd_o == 4'h0) else $error("rxd not low");
	a_nib_hold: assert property ($rose(rx_dv_o) |=> $stable(rxd_o)[*4]) else $error("nibble short");
	a_tx_clk_div: assert property (speed_100_i[*8] ##0 $rose(tx_clk_o) ##1 speed_100_i[*5] |-> $rose(tx_clk_o))
		else $error("tx clock period");
endmodule
bind plcr_top plcr_top_chk i_chk (.core_clk_i, .rst_i, .speed_100_i, .squelch_ok_i, .eq_settled_i,
	.tx_clk_o, .tx_line_oe_o, .pll_src_line_o, .rx_clk_o, .rxd_o, .rx_dv_o, .rx_er_o, .loss_sync_o, .retrain_o);
`default_nettype wire

//--- test/plcr_remote.sv
/*
 plcr_remote: far-end transceiver that echoes our line and makes PLL ticks.
 Assumes one line bit or half cell per core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module plcr_remote (
	input wire logic	core_clk_i,
	input wire logic	loop_i,
	input wire logic [2:0]	tick_per_i,
	input wire logic	line_i,
	input wire logic	line_oe_i,
	output logic	line_o,
	output logic	squelch_o,
	output logic	eq_o,
	output logic	tick_o
);
	logic [2:0]	tcnt_ff;
	// start quiet so nothing unknown reaches the sync chains
	initial begin
		tcnt_ff = 3'h0;
		line_o = 1'b0;
		tick_o = 1'b0;
	end
	// echo while driven; an undriven pair toggles rather than holding
	always @(posedge core_clk_i) begin
		squelch_o <= loop_i && line_oe_i;
		eq_o <= loop_i && line_oe_i;
		line_o <= (loop_i && line_oe_i) ? line_i : ~line_o;
	end
	// one tick per tick_per_i cycles
	always @(posedge core_clk_i) begin
		tcnt_ff <= (tcnt_ff + 3'h1 >= tick_per_i) ? 3'h0 : tcnt_ff + 3'h1;
		tick_o <= (tcnt_ff < {1'b0, tick_per_i[2:1]});
	end
endmodule
`default_nettype wire

//--- test/plcr_top_tb.sv
/*
 plcr_top_tb: directed bench for plcr_top, line looped by plcr_remote.
 Assumes the checker is bound on its own; inputs change at falling edges.
*/
`timescale 1ns/100ps
`default_nettype none
module plcr_top_tb;
	import plcr_pkg::*;
	logic	core_clk = 1'b0;
	logic	rst = 1'b1;
	logic	spd = 1'b1;
	logic	txen = 1'b0;
	logic	loop = 1'b0;
	logic [3:0]	txd = 4'h0;
	logic [2:0]	tper = 3'h4;
	logic	tx_ready, tx_clk, tx_line, tx_oe, rx_line, sq, eq, tick, src, rx_clk;
	logic	rx_dv, rx_er, ssd, esd, cerr, lsync, retr;
	logic [3:0]	rxd;
	int	n_fail = 0;
	int	n_tests = 0;
	int	cyc = 0;
	plcr_top #(.SYNC_WIN(200)) i_dut (.core_clk_i(core_clk), .rst_i(rst), .speed_100_i(spd),
		.status_clr_i(1'b0), .txd_i(txd), .tx_en_i(txen), .tx_ready_o(tx_ready), .tx_clk_o(tx_clk),
		.tx_line_o(tx_line), .tx_line_oe_o(tx_oe), .rx_line_i(rx_line), .squelch_ok_i(sq),
		.eq_settled_i(eq), .pll_tick_i(tick), .pll_src_line_o(src), .rx_clk_o(rx_clk), .rxd_o(rxd),
		.rx_dv_o(rx_dv), .rx_er_o(rx_er), .ssd_err_o(ssd), .esd_err_o(esd), .code_err_o(cerr),
		.loss_sync_o(lsync), .retrain_o(retr));
	plcr_remote i_rem (.core_clk_i(core_clk), .loop_i(loop), .tick_per_i(tper), .line_i(tx_line),
		.line_oe_i(tx_oe), .line_o(rx_line), .squelch_o(sq), .eq_o(eq), .tick_o(tick));
	// 10 MHz core clock
	always #50 core_clk = ~core_clk;
	task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s exp %0h got %0h", what, exp, got);
		end
	endtask
	// holds the nibble until the fifo takes it
	task automatic push(input logic [3:0] n);
		txen = 1'b1;
		txd = n;
		while (tx_ready !== 1'b1) @(negedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic t_fast();
		logic [31:0] pk;
		logic [39:0] got;
		logic er;
		pk = 32'h5555df10;
		got = '0;
		er = 1'b0;
		loop = 1'b1;
		repeat (400) @(negedge core_clk);
		chk("loss of sync", 72'h0, 72'(lsync));
		for (int i = 0; i < 8; i++) push(pk[31-4*i -: 4]);
		txen = 1'b0;
		while (rx_dv !== 1'b1) @(negedge core_clk);
		for (int i = 0; i < 10; i++) begin
			got = {got[35:0], rxd};
			er = er | rx_er;
			repeat (5) @(negedge core_clk);
		end
		chk("rx nibbles", 72'h5555df1000, 72'(got));
		chk("rx error", 72'h0, 72'(er));
		chk("error status", 72'h0, 72'({ssd, esd, cerr}));
		chk("rx valid after end", 72'h0, 72'(rx_dv));
		$display("fast loop test done");
	endtask
	task automatic t_fill();
		int k;
		k = 0;
		txen = 1'b1;
		txd = 4'h5;
		while (tx_ready === 1'b1 && k < 20) begin
			@(negedge core_clk);
			k++;
		end
		txen = 1'b0;
		chk("fifo refused", 72'h1, 72'(k < 20));
		repeat (300) @(negedge core_clk);
		chk("fifo drained", 72'h1, 72'(tx_ready));
		$display("fifo test done");
	endtask
	task automatic t_slow();
		logic [71:0] exp;
		logic [71:0] got;
		logic [31:0] pk;
		logic [3:0] n;
		logic [19:0] nibs;
		int k;
		pk = 32'h5555555d;
		nibs = '0;
		exp = '1;
		got = '0;
		k = 0;
		spd = 1'b0;
		repeat (20) @(negedge core_clk);
		chk("sync flag at 10", 72'h1, 72'(lsync));
		// lsb first, complement half then true half; idle pulse stays high
		for (int i = 0; i < 8; i++) begin
			n = pk[31-4*i -: 4];
			for (int b = 0; b < 4; b++) exp[71-8*i-2*b -: 2] = {~n[b], n[b]};
		end
		fork
			begin
				for (int i = 0; i < 8; i++) push(pk[31-4*i -: 4]);
				txen = 1'b0;
			end
			begin
				while (tx_oe !== 1'b1) @(negedge core_clk);
				while (tx_oe === 1'b1 && k < 80) begin
					got = {got[70:0], tx_line};
					k++;
					@(negedge core_clk);
				end
			end
			begin
				// 12 bit times of lock eat three preamble nibbles, four remain
				while (rx_dv !== 1'b1) @(negedge core_clk);
				for (int i = 0; i < 5; i++) begin
					nibs = {nibs[15:0], rxd};
					repeat (8) @(negedge core_clk);
				end
				chk("rx nibbles at 10", 72'h5555d, 72'(nibs));
				chk("rx valid after idle pulse", 72'h0, 72'(rx_dv));
			end
		join
		chk("manchester halves", exp, got);
		chk("driven halves", 72'd72, 72'(k));
		repeat (100) @(negedge core_clk);
		$display("slow test done");
	endtask
	task automatic t_retrain();
		int k;
		k = 0;
		spd = 1'b1;
		tper = 3'h3;
		while (retr !== 1'b1 && k < 400) begin
			@(negedge core_clk);
			k++;
		end
		tper = 3'h4;
		chk("pll source", 72'h0, 72'(src));
		k = 0;
		while (retr === 1'b1 && k < 3000) begin
			@(negedge core_clk);
			k++;
		end
		chk("retrain cycles", 72'(RETRAIN_CYC), 72'(k));
		$display("retrain test done");
	endtask
	task automatic end_sim();
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// hang guard, about six times the planned run
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	// reset, then the scenarios in turn
	initial begin
		repeat (6) @(negedge core_clk);
		chk("reset outputs", 72'h18, 72'({tx_ready, lsync, rx_dv, retr, ssd}));
		rst = 1'b0;
		repeat (10) @(negedge core_clk);
		t_fast();
		t_fill();
		t_slow();
		t_retrain();
		end_sim();
	end
endmodule
`default_nettype wire
